// ### core/pss_pkg.sv
// shared constants, types and register map of the program stage sequencer
package pss_pkg;

	////////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CLK_KHZ          = 40000;
	localparam int TENTH_UNIT_MS    = 100;
	localparam int STAGE_PULSE_MS   = 250;
	localparam int TENTH_CYCLES     = TENTH_UNIT_MS * CLK_KHZ;
	localparam int STAGE_PULSE_CYCLES = STAGE_PULSE_MS * CLK_KHZ;
	localparam int SEC_PER_MIN      = 60;

	////////////////////////////////////////////////////////////////////////////
	// program geometry
	localparam int          NUM_STAGES = 15;
	localparam int          STAGE_W    = 4;
	localparam int          DUR_W      = 16;
	localparam int          CODE_W     = 3;
	localparam logic [15:0] DUR_MAX    = 16'h8ca0;
	localparam int          CODE_REV_BIT = 2;

	////////////////////////////////////////////////////////////////////////////
	// register map, byte addresses
	localparam int         ADDR_W        = 8;
	localparam logic [7:0] CTRL_OFS      = 8'h00;
	localparam logic [7:0] CMD_OFS       = 8'h04;
	localparam logic [7:0] STATUS_OFS    = 8'h08;
	localparam logic [7:0] IRQ_STAT_OFS  = 8'h0c;
	localparam logic [7:0] IRQ_MASK_OFS  = 8'h10;
	localparam logic [7:0] DUR_BASE      = 8'h40;
	localparam logic [7:0] DUR_END       = 8'h78;
	localparam logic [7:0] CODE_BASE     = 8'h80;
	localparam logic [7:0] CODE_END      = 8'hb8;

	// field positions
	localparam int CTRL_MODE_LSB  = 0;
	localparam int CTRL_TB_BIT    = 2;
	localparam int CTRL_REC_LSB   = 4;
	localparam int CMD_RUN_BIT    = 0;
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_STAGE_LSB = 4;
	localparam int STAT_STAGE_P_BIT = 8;
	localparam int STAT_CYCLE_P_BIT = 9;
	localparam int STAT_ELAPSED_LSB = 16;

	// interrupt bits
	localparam int IRQ_W     = 3;
	localparam int IRQ_STAGE = 0;
	localparam int IRQ_CYCLE = 1;
	localparam int IRQ_DONE  = 2;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	////////////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [1:0] {
		CYC_ONCE = 2'b00,
		CYC_LOOP = 2'b01,
		CYC_HOLD = 2'b10
	} pss_cycle_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN  = 2'b01,
		ST_HOLD = 2'b10
	} pss_state_e;

	typedef struct packed {
		logic       run;
		logic       reverse;
		logic [1:0] accel_set;
		logic       hold_final;
	} pss_drive_s;

endpackage

// ### core/pss_tick_div.sv
// cycle divider issuing a one-cycle tick every DIV enabled cycles
`timescale 1ns/1ps
module pss_tick_div #(
	parameter int DIV = 4
) (
	input  wire logic core_clk,
	input  wire logic sys_rst,
	input  wire logic clear,
	input  wire logic enable,
	output logic      tick
);
	localparam int CW = $clog2(DIV + 1);

	logic [CW-1:0] cnt_reg;

	always_ff @(posedge core_clk) begin
		if (sys_rst || clear) begin
			cnt_reg <= '0;
			tick    <= 1'b0;
		end else begin
			tick <= 1'b0;
			if (enable) begin
				if (cnt_reg == CW'(DIV - 1)) begin
					cnt_reg <= '0;
					tick    <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg + 1'b1;
				end
			end
		end
	end
endmodule

// ### core/pss_pulse_stretch.sv
// stretches a one-cycle trigger into a pulse of LEN cycles
`timescale 1ns/1ps
module pss_pulse_stretch #(
	parameter int LEN = 4
) (
	input  wire logic core_clk,
	input  wire logic sys_rst,
	input  wire logic trigger,
	output logic      pulse
);
	localparam int CW = $clog2(LEN + 1);

	logic [CW-1:0] left_reg;

	// retrigger restarts the width; close events merge
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			left_reg <= '0;
			pulse    <= 1'b0;
		end else if (trigger) begin
			left_reg <= CW'(LEN - 1);
			pulse    <= 1'b1;
		end else if (left_reg != '0) begin
			left_reg <= left_reg - 1'b1;
		end else begin
			pulse <= 1'b0;
		end
	end
endmodule

// ### core/pss_sequencer.sv
// program stage sequencer with its axi4-lite register slave
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps

// Summary of operation
// - cycle mode 0: run all stages once, then stop the drive
// - cycle mode 1: wrap from last stage back to first, forever
// - cycle mode 2: after one cycle keep the final stage running
// - time base bit: 0 counts seconds, 1 counts minutes
// - fifteen stage durations, in tenths, 0.0 to 3600.0 units
// - run code 0..3: forward with acceleration set 1..4
// - run code 4..7: reverse with acceleration set 1..4
// - record 0: stop discards progress, next run starts stage one
// - record 1 or 2: stop pauses, next run resumes at breakpoint
// - writing cycle mode while stopped clears the recorded progress
// - each completed stage gives one 250 ms pulse
// - each completed cycle gives one 250 ms pulse
module pss_sequencer #(
	parameter int TENTH_CYCLES = pss_pkg::TENTH_CYCLES,
	parameter int MIN_FACTOR   = pss_pkg::SEC_PER_MIN,
	parameter int PULSE_CYCLES = pss_pkg::STAGE_PULSE_CYCLES
) (
	input  wire logic                       core_clk,
	input  wire logic                       sys_rst,
	input  wire logic [pss_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [pss_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	output pss_pkg::pss_drive_s             drive_cmd,
	output logic [pss_pkg::STAGE_W-1:0]     stage_num,
	output logic                            stage_end_pulse,
	output logic                            cycle_end_pulse,
	output logic                            irq
);

	////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [31:0] pss_merge(
		input logic [31:0] old_val,
		input logic [31:0] new_val,
		input logic [3:0]  strb
	);
		logic [31:0] res;
		res = old_val;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = new_val[b*8 +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic [pss_pkg::STAGE_W-1:0] pss_index(
		input logic [pss_pkg::ADDR_W-1:0] addr,
		input logic [pss_pkg::ADDR_W-1:0] base
	);
		logic [pss_pkg::ADDR_W-1:0] ofs;
		ofs = addr - base;
		return ofs[pss_pkg::STAGE_W+1:2];
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// declarations

	logic                         aw_held_reg;
	logic [pss_pkg::ADDR_W-1:0]   aw_addr_reg;
	logic                         w_held_reg;
	logic [31:0]                  w_data_reg;
	logic [3:0]                   w_strb_reg;
	logic                         aw_fire;
	logic                         w_fire;
	logic                         ar_fire;
	logic                         wr_do;
	logic                         wr_dur_hit;
	logic                         wr_code_hit;
	logic                         wr_known;
	logic [pss_pkg::STAGE_W-1:0]  wr_idx;
	logic [31:0]                  wr_dur_val;
	logic [31:0]                  wr_ctrl_val;
	logic [31:0]                  rd_data;
	logic                         rd_err;
	logic [pss_pkg::STAGE_W-1:0]  rd_idx;

	logic [pss_pkg::DUR_W-1:0]    dur_mem  [pss_pkg::NUM_STAGES];
	logic [pss_pkg::CODE_W-1:0]   code_mem [pss_pkg::NUM_STAGES];
	logic [1:0]                   cycle_mode_select_reg;
	logic                         time_base_select_reg;
	logic [1:0]                   record_option_reg;
	logic                         run_req_reg;
	logic                         run_prev_reg;
	logic [pss_pkg::IRQ_W-1:0]    irq_stat_reg;
	logic [pss_pkg::IRQ_W-1:0]    irq_mask_reg;
	logic [pss_pkg::IRQ_W-1:0]    irq_set;
	logic                         irq_clr;

	pss_pkg::pss_state_e          state_reg;
	logic [pss_pkg::STAGE_W-1:0]  stage_reg;
	logic [pss_pkg::DUR_W-1:0]    elapsed_reg;
	logic                         start;
	logic                         stop;
	logic                         ctrl_wr_idle;
	logic                         advance;
	logic                         last_stage;
	logic                         tenth_tick;
	logic                         min_tick;
	logic                         unit_tick;
	logic                         div_clear;
	logic                         single_done;

	////////////////////////////////////////////////////////////////////////////
	// axi4-lite write channel

	assign aw_fire = s_axi_awvalid && s_axi_awready;
	assign w_fire  = s_axi_wvalid && s_axi_wready;
	assign wr_do   = aw_held_reg && w_held_reg && !s_axi_bvalid;

	assign wr_dur_hit  = (aw_addr_reg >= pss_pkg::DUR_BASE) && (aw_addr_reg <= pss_pkg::DUR_END);
	assign wr_code_hit = (aw_addr_reg >= pss_pkg::CODE_BASE) && (aw_addr_reg <= pss_pkg::CODE_END);
	assign wr_idx      = wr_dur_hit ? pss_index(aw_addr_reg, pss_pkg::DUR_BASE)
	                                : pss_index(aw_addr_reg, pss_pkg::CODE_BASE);
	assign wr_known    = wr_dur_hit || wr_code_hit ||
	                     aw_addr_reg == pss_pkg::CTRL_OFS || aw_addr_reg == pss_pkg::CMD_OFS ||
	                     aw_addr_reg == pss_pkg::STATUS_OFS ||
	                     aw_addr_reg == pss_pkg::IRQ_STAT_OFS ||
	                     aw_addr_reg == pss_pkg::IRQ_MASK_OFS;
	assign wr_dur_val  = pss_merge({16'h0, dur_mem[wr_idx]}, w_data_reg, w_strb_reg);
	assign wr_ctrl_val = pss_merge({26'h0, record_option_reg, 1'b0, time_base_select_reg,
	                                cycle_mode_select_reg}, w_data_reg, w_strb_reg);

	// address and data are taken in either order; ready drops while one is held
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			aw_held_reg   <= 1'b0;
			aw_addr_reg   <= '0;
			w_held_reg    <= 1'b0;
			w_data_reg    <= '0;
			w_strb_reg    <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= pss_pkg::RESP_OKAY;
		end else begin
			if (aw_fire) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end else if (wr_do) begin
				aw_held_reg <= 1'b0;
			end
			if (w_fire) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end else if (wr_do) begin
				w_held_reg <= 1'b0;
			end
			s_axi_awready <= !(aw_fire || (aw_held_reg && !wr_do));
			s_axi_wready  <= !(w_fire || (w_held_reg && !wr_do));
			if (wr_do) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_known ? pss_pkg::RESP_OKAY : pss_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// software-written registers

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			for (int i = 0; i < pss_pkg::NUM_STAGES; i++) begin
				dur_mem[i]  <= '0;
				code_mem[i] <= '0;
			end
			cycle_mode_select_reg <= pss_pkg::CYC_ONCE;
			time_base_select_reg  <= 1'b0;
			record_option_reg     <= 2'h0;
			run_req_reg           <= 1'b0;
			irq_mask_reg          <= '0;
		end else if (wr_do) begin
			if (wr_dur_hit) begin
				// out-of-range durations saturate at 3600.0
				dur_mem[wr_idx] <= (wr_dur_val > {16'h0, pss_pkg::DUR_MAX}) ?
				                   pss_pkg::DUR_MAX : wr_dur_val[pss_pkg::DUR_W-1:0];
			end
			if (wr_code_hit && w_strb_reg[0]) begin
				code_mem[wr_idx] <= w_data_reg[pss_pkg::CODE_W-1:0];
			end
			if (aw_addr_reg == pss_pkg::CTRL_OFS) begin
				cycle_mode_select_reg <= wr_ctrl_val[pss_pkg::CTRL_MODE_LSB +: 2];
				time_base_select_reg  <= wr_ctrl_val[pss_pkg::CTRL_TB_BIT];
				record_option_reg     <= wr_ctrl_val[pss_pkg::CTRL_REC_LSB +: 2];
			end
			if (aw_addr_reg == pss_pkg::CMD_OFS && w_strb_reg[0]) begin
				run_req_reg <= w_data_reg[pss_pkg::CMD_RUN_BIT];
			end
			if (aw_addr_reg == pss_pkg::IRQ_MASK_OFS && w_strb_reg[0]) begin
				irq_mask_reg <= w_data_reg[pss_pkg::IRQ_W-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// axi4-lite read channel

	assign ar_fire = s_axi_arvalid && s_axi_arready;
	assign rd_idx  = (s_axi_araddr >= pss_pkg::CODE_BASE) ?
	                 pss_index(s_axi_araddr, pss_pkg::CODE_BASE) :
	                 pss_index(s_axi_araddr, pss_pkg::DUR_BASE);

	always_comb begin
		rd_data = '0;
		rd_err  = 1'b0;
		if (s_axi_araddr >= pss_pkg::DUR_BASE && s_axi_araddr <= pss_pkg::DUR_END) begin
			rd_data[pss_pkg::DUR_W-1:0] = dur_mem[rd_idx];
		end else if (s_axi_araddr >= pss_pkg::CODE_BASE && s_axi_araddr <= pss_pkg::CODE_END) begin
			rd_data[pss_pkg::CODE_W-1:0] = code_mem[rd_idx];
		end else begin
			case (s_axi_araddr)
				pss_pkg::CTRL_OFS: begin
					rd_data[pss_pkg::CTRL_MODE_LSB +: 2] = cycle_mode_select_reg;
					rd_data[pss_pkg::CTRL_TB_BIT]        = time_base_select_reg;
					rd_data[pss_pkg::CTRL_REC_LSB +: 2]  = record_option_reg;
				end
				pss_pkg::CMD_OFS: rd_data[pss_pkg::CMD_RUN_BIT] = run_req_reg;
				pss_pkg::STATUS_OFS: begin
					rd_data[pss_pkg::STAT_STATE_LSB +: 2]                 = state_reg;
					rd_data[pss_pkg::STAT_STAGE_LSB +: pss_pkg::STAGE_W]  = stage_reg;
					rd_data[pss_pkg::STAT_STAGE_P_BIT]                    = stage_end_pulse;
					rd_data[pss_pkg::STAT_CYCLE_P_BIT]                    = cycle_end_pulse;
					rd_data[pss_pkg::STAT_ELAPSED_LSB +: pss_pkg::DUR_W]  = elapsed_reg;
				end
				pss_pkg::IRQ_STAT_OFS: rd_data[pss_pkg::IRQ_W-1:0] = irq_stat_reg;
				pss_pkg::IRQ_MASK_OFS: rd_data[pss_pkg::IRQ_W-1:0] = irq_mask_reg;
				default: rd_err = 1'b1;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= pss_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= !ar_fire && !(s_axi_rvalid && !s_axi_rready);
			if (ar_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_data;
				s_axi_rresp  <= rd_err ? pss_pkg::RESP_SLVERR : pss_pkg::RESP_OKAY;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// time base

	// prescaler restarts on stage entry so each stage gets whole tenths
	assign div_clear = (state_reg != pss_pkg::ST_RUN) || advance;

	pss_tick_div #(.DIV(TENTH_CYCLES)) u_tenth_div (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.clear    (div_clear),
		.enable   (1'b1),
		.tick     (tenth_tick)
	);

	pss_tick_div #(.DIV(MIN_FACTOR)) u_min_div (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.clear    (div_clear),
		.enable   (tenth_tick),
		.tick     (min_tick)
	);

	assign unit_tick = time_base_select_reg ? min_tick : tenth_tick;

	////////////////////////////////////////////////////////////////////////////
	// stage sequencing

	assign start        = run_req_reg && !run_prev_reg;
	assign stop         = !run_req_reg && run_prev_reg;
	assign ctrl_wr_idle = wr_do && aw_addr_reg == pss_pkg::CTRL_OFS &&
	                      state_reg == pss_pkg::ST_IDLE;
	assign last_stage   = stage_reg == pss_pkg::STAGE_W'(pss_pkg::NUM_STAGES - 1);
	// a zero duration stage is passed in a single cycle
	assign advance      = state_reg == pss_pkg::ST_RUN && !stop &&
	                      elapsed_reg >= dur_mem[stage_reg];
	assign single_done  = advance && last_stage &&
	                      cycle_mode_select_reg != pss_pkg::CYC_LOOP &&
	                      cycle_mode_select_reg != pss_pkg::CYC_HOLD;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			run_prev_reg <= 1'b0;
		end else begin
			run_prev_reg <= run_req_reg;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_reg   <= pss_pkg::ST_IDLE;
			stage_reg   <= '0;
			elapsed_reg <= '0;
		end else begin
			case (state_reg)
				pss_pkg::ST_IDLE: begin
					if (ctrl_wr_idle) begin
						stage_reg   <= '0;
						elapsed_reg <= '0;
					end
					// progress left by a paused run is picked up here
					if (start) begin
						state_reg <= pss_pkg::ST_RUN;
					end
				end
				pss_pkg::ST_RUN: begin
					if (stop) begin
						state_reg <= pss_pkg::ST_IDLE;
						if (record_option_reg == 2'h0) begin
							stage_reg   <= '0;
							elapsed_reg <= '0;
						end
					end else if (advance) begin
						elapsed_reg <= '0;
						if (!last_stage) begin
							stage_reg <= stage_reg + 1'b1;
						end else begin
							case (cycle_mode_select_reg)
								pss_pkg::CYC_LOOP: stage_reg <= '0;
								pss_pkg::CYC_HOLD: state_reg <= pss_pkg::ST_HOLD;
								default: begin
									state_reg <= pss_pkg::ST_IDLE;
									stage_reg <= '0;
								end
							endcase
						end
					end else if (unit_tick && elapsed_reg != '1) begin
						elapsed_reg <= elapsed_reg + 1'b1;
					end
				end
				pss_pkg::ST_HOLD: begin
					if (stop) begin
						state_reg   <= pss_pkg::ST_IDLE;
						stage_reg   <= '0;
						elapsed_reg <= '0;
					end
				end
				default: state_reg <= pss_pkg::ST_IDLE;
			endcase
		end
	end

	assign stage_num = stage_reg;

	////////////////////////////////////////////////////////////////////////////
	// drive command, one cycle behind the stage register

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			drive_cmd <= '0;
		end else begin
			drive_cmd.run        <= state_reg != pss_pkg::ST_IDLE;
			drive_cmd.reverse    <= code_mem[stage_reg][pss_pkg::CODE_REV_BIT];
			drive_cmd.accel_set  <= code_mem[stage_reg][1:0];
			drive_cmd.hold_final <= state_reg == pss_pkg::ST_HOLD;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// completion pulses and interrupts

	pss_pulse_stretch #(.LEN(PULSE_CYCLES)) u_stage_pulse (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.trigger  (advance),
		.pulse    (stage_end_pulse)
	);

	pss_pulse_stretch #(.LEN(PULSE_CYCLES)) u_cycle_pulse (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.trigger  (advance && last_stage),
		.pulse    (cycle_end_pulse)
	);

	always_comb begin
		irq_set            = '0;
		irq_set[pss_pkg::IRQ_STAGE] = advance;
		irq_set[pss_pkg::IRQ_CYCLE] = advance && last_stage;
		irq_set[pss_pkg::IRQ_DONE]  = single_done;
	end

	assign irq_clr = ar_fire && s_axi_araddr == pss_pkg::IRQ_STAT_OFS;

	// a new event in the clearing cycle survives the read
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			irq_stat_reg <= '0;
			irq <= 1'b0;
		end else begin
			irq_stat_reg <= (irq_clr ? '0 : irq_stat_reg) | irq_set;
			irq <= |(irq_stat_reg & irq_mask_reg);
		end
	end

endmodule

// ### dv/pss_sequencer_asserts.sv
// assertion checker for the program stage sequencer
`timescale 1ns/1ps
module pss_sequencer_chk #(
	parameter int PULSE_CYCLES = 5
) (
	input wire logic                core_clk,
	input wire logic                sys_rst,
	input wire logic                s_axi_arvalid,
	input wire logic                s_axi_arready,
	input wire logic [31:0]         s_axi_rdata,
	input wire logic                s_axi_rvalid,
	input wire logic                s_axi_rready,
	input wire logic [1:0]          s_axi_bresp,
	input wire logic                s_axi_bvalid,
	input wire logic                s_axi_bready,
	input wire pss_pkg::pss_drive_s drive_cmd,
	input wire logic [3:0]          stage_num,
	input wire logic                stage_end_pulse,
	input wire logic                cycle_end_pulse
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	// retrigger stretches pulses: check minimum width only
	logic [31:0] pulse_len_reg;
	always_ff @(posedge core_clk) begin
		if (sys_rst || !stage_end_pulse)
			pulse_len_reg <= 32'h0;
		else
			pulse_len_reg <= pulse_len_reg + 32'h1;
	end

	////////////////////////////////////////////////////////////////////////////
	property p_pulse_len;
		$fell(stage_end_pulse) |-> pulse_len_reg >= PULSE_CYCLES;
	endproperty
	a_pulse_len: assert property (p_pulse_len)
		else $error("stage pulse too short");
	property p_cycle_pair;
		$rose(cycle_end_pulse) |-> stage_end_pulse;
	endproperty
	a_cycle_pair: assert property (p_cycle_pair)
		else $error("cycle pulse without stage pulse");
	property p_hold_run;
		drive_cmd.hold_final |-> drive_cmd.run;
	endproperty
	a_hold_run: assert property (p_hold_run)
		else $error("final hold while not running");
	property p_stage_range;
		stage_num <= 4'he;
	endproperty
	a_stage_range: assert property (p_stage_range)
		else $error("stage index out of range");
	property p_stage_step;
		$changed(stage_num) |-> stage_num == $past(stage_num) + 4'h1 || stage_num == 4'h0;
	endproperty
	a_stage_step: assert property (p_stage_step)
		else $error("stage skipped");
	property p_rd_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("read answer late");
	property p_rd_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold)
		else $error("read data dropped");
	property p_wr_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_wr_hold: assert property (p_wr_hold)
		else $error("write response dropped");

	c_cycle: cover property ($rose(cycle_end_pulse));
	c_hold: cover property ($rose(drive_cmd.hold_final));
	c_rev: cover property (drive_cmd.run && drive_cmd.reverse);
endmodule

bind pss_sequencer pss_sequencer_chk #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk (
	.core_clk, .sys_rst, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .drive_cmd, .stage_num,
	.stage_end_pulse, .cycle_end_pulse
);

// ### dv/tb.sv
// self-checking bench for the program stage sequencer
`timescale 1ns/1ps
module tb;
	localparam logic [1:0] ok_resp  = pss_pkg::RESP_OKAY;
	logic                core_clk      = 1'b0;
	logic                sys_rst       = 1'b1;
	logic [7:0]          s_axi_awaddr  = 8'h00;
	logic                s_axi_awvalid = 1'b0;
	logic [31:0]         s_axi_wdata   = 32'h0;
	logic [3:0]          s_axi_wstrb   = 4'hf;
	logic                s_axi_wvalid  = 1'b0;
	logic                s_axi_bready  = 1'b1;
	logic [7:0]          s_axi_araddr  = 8'h00;
	logic                s_axi_arvalid = 1'b0;
	logic                s_axi_rready  = 1'b1;
	logic                s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic                s_axi_rvalid, stage_end_pulse, cycle_end_pulse, irq;
	logic [1:0]          s_axi_bresp, s_axi_rresp;
	logic [31:0]         s_axi_rdata;
	logic [3:0]          stage_num;
	pss_pkg::pss_drive_s drive_cmd;
	logic [1:0]          exp_b[$];
	logic [65:0]         exp_r[$];
	logic [2:0]          code[15];
	logic [31:0]         seed          = 32'ha2272834;
	int                  checks        = 0;
	int                  miscompares   = 0;

	always #12.5 core_clk = ~core_clk;

	pss_sequencer #(.TENTH_CYCLES(4), .MIN_FACTOR(3), .PULSE_CYCLES(5)) u_dut (
		.core_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .drive_cmd, .stage_num,
		.stage_end_pulse, .cycle_end_pulse, .irq
	);

	////////////////////////////////////////////////////////////////////////////
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task end_of_test();
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task tmo();
		chk(32'h0, 32'h1);
		end_of_test();
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		exp_b.push_back(r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
			if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
			n++;
		end while (!s_axi_bvalid && n < 100);
		if (n >= 100) tmo();
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
			input logic [1:0] r);
		int n;
		exp_r.push_back({r, m, e});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
			n++;
		end while (!s_axi_rvalid && n < 100);
		if (n >= 100) tmo();
	endtask

	always @(posedge core_clk) begin
		logic [65:0] e;
		if (s_axi_bvalid && s_axi_bready) chk({30'h0, s_axi_bresp}, {30'h0, exp_b.pop_front()});
		if (s_axi_rvalid && s_axi_rready) begin
			e = exp_r.pop_front();
			chk(s_axi_rdata & e[63:32], e[31:0]);
			chk({30'h0, s_axi_rresp}, {30'h0, e[65:64]});
		end
	end

	task automatic wait_stage(input logic [3:0] s);
		int n;
		n = 0;
		while (stage_num !== s && n < 3000) begin
			@(posedge core_clk);
			n++;
		end
		if (n >= 3000) tmo();
	endtask

	task automatic wait_drv(input logic [4:0] m, input logic [4:0] v);
		int n;
		n = 0;
		while ((drive_cmd & m) !== v && n < 3000) begin
			@(posedge core_clk);
			n++;
		end
		if (n >= 3000) tmo();
	endtask

	task automatic meas(input int lo, input int hi);
		int n;
		n = 0;
		while (stage_num === 4'h1 && n < 60) begin
			@(posedge core_clk);
			n++;
		end
		chk({31'h0, n >= lo && n <= hi}, 32'h1);
	endtask

	task automatic run_from(input logic [31:0] c);
		wr(pss_pkg::CMD_OFS, 32'h0, ok_resp);
		wr(pss_pkg::CTRL_OFS, c, ok_resp);
		wr(pss_pkg::CMD_OFS, 32'h1, ok_resp);
		repeat (3) @(posedge core_clk);
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [2:0] r;
		repeat (8) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd(pss_pkg::CTRL_OFS, 32'h0, 32'hffffffff, ok_resp);
		rd(pss_pkg::IRQ_MASK_OFS, 32'h0, 32'hffffffff, ok_resp);
		rd(8'hfc, 32'h0, 32'hffffffff, pss_pkg::RESP_SLVERR);
		wr(8'hfc, 32'h1, pss_pkg::RESP_SLVERR);
		wr(pss_pkg::DUR_BASE, 32'hffff, ok_resp);
		rd(pss_pkg::DUR_BASE, 32'h8ca0, 32'hffffffff, ok_resp);
		$display("test regs done");
		r = rnd() >> 7;
		for (int i = 0; i < 15; i++) begin
			code[i] = 3'(i) + r;
			wr(pss_pkg::DUR_BASE + 8'(4 * i), 32'h2, ok_resp);
			wr(pss_pkg::CODE_BASE + 8'(4 * i), {29'h0, code[i]}, ok_resp);
		end
		wr(pss_pkg::IRQ_MASK_OFS, 32'h7, ok_resp);
		run_from(32'h0);
		for (int i = 0; i < 15; i++) begin
			wait_stage(4'(i));
			repeat (2) @(posedge core_clk);
			chk({27'h0, drive_cmd}, {27'h0, 1'b1, code[i], 1'b0});
			if (i == 1) meas(4, 10);
		end
		wait_drv(5'h10, 5'h00);
		repeat (2) @(posedge core_clk);
		chk({31'h0, irq}, 32'h1);
		wr(pss_pkg::IRQ_MASK_OFS, 32'h0, ok_resp);
		repeat (2) @(posedge core_clk);
		chk({31'h0, irq}, 32'h0);
		wr(pss_pkg::IRQ_MASK_OFS, 32'h7, ok_resp);
		rd(pss_pkg::IRQ_STAT_OFS, 32'h7, 32'h7, ok_resp);
		rd(pss_pkg::IRQ_STAT_OFS, 32'h0, 32'h7, ok_resp);
		repeat (2) @(posedge core_clk);
		chk({31'h0, irq}, 32'h0);
		$display("test once done");
		run_from(32'h5);
		wait_stage(4'h1);
		meas(21, 28);
		wait_stage(4'he);
		wait_stage(4'h0);
		repeat (3) @(posedge core_clk);
		chk({31'h0, drive_cmd.run}, 32'h1);
		$display("test loop done");
		run_from(32'h2);
		wait_drv(5'h01, 5'h01);
		chk({27'h0, drive_cmd}, {27'h0, 1'b1, code[14], 1'b1});
		rd(pss_pkg::STATUS_OFS, 32'h2, 32'h3, ok_resp);
		$display("test hold done");
		run_from(32'h10);
		wait_stage(4'h3);
		wr(pss_pkg::CMD_OFS, 32'h0, ok_resp);
		wr(pss_pkg::CMD_OFS, 32'h1, ok_resp);
		repeat (3) @(posedge core_clk);
		chk({31'h0, stage_num >= 4'h3}, 32'h1);
		run_from(32'h10);
		chk({31'h0, stage_num <= 4'h1}, 32'h1);
		run_from(32'h0);
		wait_stage(4'h3);
		wr(pss_pkg::CMD_OFS, 32'h0, ok_resp);
		wr(pss_pkg::CMD_OFS, 32'h1, ok_resp);
		repeat (3) @(posedge core_clk);
		chk({31'h0, stage_num <= 4'h1}, 32'h1);
		$display("test record done");
		end_of_test();
	end
endmodule
